// >>> hdl/switch_box_power_status_ctrl.sv
// Power-state, status indicator, probe relay and APB registers of the box.
`timescale 1ns/1ps

// Overview of operation
// [RL1] On battery above the low threshold the status lamp blinks green slowly.
// [RL2] On battery below the low threshold the status lamp blinks red slowly.
// [RL3] On external supply with full batteries it blinks green quickly.
// [RL4] On external supply while charging it blinks yellow quickly.
// [RL5] A short press of the power button toggles between on and off.
// [RL6] Holding the button past the limit forces an immediate shutdown.
// [RL7] Attaching the charger powers the unit on without a button press.
// [RL8] While the charger is attached the button cannot switch the unit off; the code still lets a long hold force the shutdown.
// [RL9] On battery, a full idle period without traffic switches the unit off; the code holds the idle count at zero in firmware load mode.
// [RL10] Each probe lamp blinks while a live device is seen on its fibre.
// [RL11] Up to four probe ports are relayed through the one serial link.
// [RL12] Up to four chained units give the host at most sixteen devices.
// [RL13] Every power-on runs the self check before normal operation.
// [RL14] A firmware image may be loaded from the host over the serial port.
// [RL15] Exactly one supply state is shown, external supply taking priority.
module switch_box_power_status_ctrl
    import pwr_status_pkg::*;
#(
    parameter int          NUM_PORTS   = PORTS_PER_UNIT,
    parameter logic [31:0] HOLD_CYCLES = HOLD_CYCLES_DFLT,
    parameter logic [39:0] IDLE_CYCLES = IDLE_CYCLES_DFLT,
    parameter logic [31:0] SLOW_CYCLES = SLOW_CYCLES_DFLT,
    parameter logic [31:0] FAST_CYCLES = FAST_CYCLES_DFLT
)(
    // Clock, reset and enable
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Power button and supply sense
    input  wire logic                 power_button,
    input  wire logic                 charger_present,
    input  wire logic                 batt_low,
    input  wire logic                 batt_charged,
    output logic                      power_hold,
    // Self check
    output logic                      selfcheck_start,
    input  wire logic                 selfcheck_done,
    input  wire logic                 selfcheck_ok,
    // Status lamp
    output logic                      led_green,
    output logic                      led_red,
    // Probe ports
    input  wire logic [NUM_PORTS-1:0] link_detect,
    input  wire logic [NUM_PORTS-1:0] probe_rx,
    output logic      [NUM_PORTS-1:0] probe_tx,
    output logic      [NUM_PORTS-1:0] port_led,
    // Host serial link
    input  wire logic                 host_rx,
    output logic                      host_tx,
    input  wire logic                 serial_activity,
    output logic                      fw_update_mode,
    // Chain ports
    input  wire logic [UNIT_W-1:0]    chain_upstream_port,
    output logic      [UNIT_W-1:0]    chain_downstream_port
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        pwr_state_t           st;
        logic [31:0]          hold_cnt;
        logic [39:0]          idle_cnt;
        logic [31:0]          slow_cnt;
        logic [31:0]          fast_cnt;
        logic                 slow_ph;
        logic                 fast_ph;
        logic                 btn_prev;
        logic                 chg_prev;
        logic                 fw_update;
        logic [SEL_W-1:0]     sel;
        logic                 led_green;
        logic                 led_red;
        logic [NUM_PORTS-1:0] port_led;
        logic                 host_space;
        logic [NUM_PORTS-1:0] probe_space;
        logic [UNIT_W-1:0]    down_id;
        logic [31:0]          prdata;
    } state_t;

    state_t               cur;
    state_t               next_cur;
    logic                 apb_wr;
    logic                 addr_hit;
    logic                 ctrl_wr;
    logic                 activity;
    logic                 forced;
    logic                 release_short;
    logic                 chg_rise;
    logic                 idle_to;
    logic [31:0]          status_word;
    logic [NUM_PORTS-1:0] next_port_led;
    logic [NUM_PORTS-1:0] next_probe_space;

    // ========================================================================
    // APB decode
    // ========================================================================
    assign pready   = clk_en;
    assign apb_wr   = psel & penable & pwrite & clk_en;
    assign addr_hit = (paddr == REG_CTRL) || (paddr == REG_STATUS) ||
                      (paddr == REG_LINK) || (paddr == REG_IDLE);
    assign pslverr  = psel & penable & ~addr_hit;
    assign ctrl_wr  = apb_wr & (paddr == REG_CTRL);

    // [RL9] Traffic restarts idle count.
    assign activity = serial_activity | (ctrl_wr & pwdata[CTRL_ACT_BIT]);

    // [RL12] Unit base address.
    assign status_word = {
        20'h0,
        chain_upstream_port, 2'h0,
        2'h0,
        cur.fw_update,
        batt_charged,
        batt_low,
        charger_present,
        cur.st
    };

    // ========================================================================
    // Events
    // ========================================================================
    // [RL6] Long hold detect.
    assign forced        = power_button &&
                           (cur.hold_cnt == HOLD_CYCLES - 32'h1);
    assign release_short = !power_button && cur.btn_prev &&
                           (cur.hold_cnt < HOLD_CYCLES);
    assign chg_rise      = charger_present && !cur.chg_prev;
    assign idle_to       = (cur.idle_cnt == IDLE_CYCLES - 40'h1);

    // ========================================================================
    // Per-port lamps and relay lines
    // ========================================================================
    for (genvar i = 0; i < NUM_PORTS; i++)
    begin : g_port
        // [RL10] Link lamp blink.
        assign next_port_led[i] = link_detect[i] & cur.slow_ph &
                                  (cur.st == ST_ON);
        // [RL11] Host to probe relay.
        assign next_probe_space[i] = (cur.st == ST_ON) &&
                                     (cur.sel == SEL_W'(i)) && !host_rx;
    end

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb
    begin
        next_cur          = cur;
        next_cur.btn_prev = power_button;
        next_cur.chg_prev = charger_present;

        if (!power_button)
            next_cur.hold_cnt = 32'h0;
        else if (cur.hold_cnt < HOLD_CYCLES)
            next_cur.hold_cnt = cur.hold_cnt + 32'h1;

        if (ctrl_wr)
        begin
            // [RL14] Firmware load mode.
            next_cur.fw_update = pwdata[CTRL_FWUP_BIT];
            next_cur.sel       = pwdata[CTRL_SEL_LSB +: SEL_W];
        end

        if (psel && !penable)
        begin
            case (paddr)
                REG_CTRL:
                    next_cur.prdata = {26'h0, cur.sel, 2'h0,
                                       cur.fw_update, 1'b0};
                REG_STATUS:
                    next_cur.prdata = status_word;
                REG_LINK:
                    next_cur.prdata = 32'(link_detect);
                REG_IDLE:
                    next_cur.prdata = cur.idle_cnt[IDLE_MSB_SHIFT +: 32];
                default:
                    next_cur.prdata = 32'h0;
            endcase
        end

        // [RL5] Press toggles power.
        case (cur.st)
            ST_OFF:
            begin
                // [RL7] Charger powers on.
                if (release_short || chg_rise)
                    next_cur.st = ST_CHECK;
            end
            ST_CHECK:
            begin
                // [RL13] Self check gate.
                if (selfcheck_done)
                    next_cur.st = selfcheck_ok ? ST_ON : ST_OFF;
            end
            ST_ON:
            begin
                // [RL8] Charger blocks off.
                if (!charger_present && (release_short || idle_to))
                    next_cur.st = ST_OFF;
            end
            ST_FORCED:
            begin
                if (!power_button)
                    next_cur.st = ST_OFF;
            end
            default:
                next_cur.st = ST_OFF;
        endcase
        // [RL6] Forced shutdown wins.
        if (forced)
            next_cur.st = ST_FORCED;

        // [RL9] Idle auto off.
        if (cur.st == ST_ON && !charger_present && !cur.fw_update &&
            !activity)
            next_cur.idle_cnt = cur.idle_cnt + 40'h1;
        else
            next_cur.idle_cnt = 40'h0;

        if (cur.slow_cnt >= SLOW_CYCLES - 32'h1)
        begin
            next_cur.slow_cnt = 32'h0;
            next_cur.slow_ph  = !cur.slow_ph;
        end
        else
            next_cur.slow_cnt = cur.slow_cnt + 32'h1;
        if (cur.fast_cnt >= FAST_CYCLES - 32'h1)
        begin
            next_cur.fast_cnt = 32'h0;
            next_cur.fast_ph  = !cur.fast_ph;
        end
        else
            next_cur.fast_cnt = cur.fast_cnt + 32'h1;

        // [RL15] Charger states first.
        if (cur.st != ST_ON)
        begin
            next_cur.led_green = 1'b0;
            next_cur.led_red   = 1'b0;
        end
        else if (charger_present)
        begin
            // [RL3] Fast green when full.
            // [RL4] Fast yellow charging.
            next_cur.led_green = cur.fast_ph;
            next_cur.led_red   = cur.fast_ph & !batt_charged;
        end
        else
        begin
            // [RL1] Slow green battery.
            // [RL2] Slow red low battery.
            next_cur.led_green = cur.slow_ph & !batt_low;
            next_cur.led_red   = cur.slow_ph & batt_low;
        end

        next_cur.port_led    = next_port_led;
        next_cur.probe_space = next_probe_space;
        // [RL11] Probe to host relay.
        next_cur.host_space  = (cur.st == ST_ON) &&
                               (32'(cur.sel) < NUM_PORTS) &&
                               !probe_rx[cur.sel];
        // [RL12] Next unit position.
        next_cur.down_id     = chain_upstream_port + UNIT_W'(1);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cur <= '0;
        else if (clk_en)
            cur <= next_cur;
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    assign prdata                = cur.prdata;
    assign power_hold            = (cur.st == ST_CHECK) || (cur.st == ST_ON);
    assign selfcheck_start       = (cur.st == ST_CHECK);
    assign led_green             = cur.led_green;
    assign led_red               = cur.led_red;
    assign port_led              = cur.port_led;
    assign probe_tx              = ~cur.probe_space;
    assign host_tx               = ~cur.host_space;
    assign fw_update_mode        = cur.fw_update;
    assign chain_downstream_port = cur.down_id;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    batt_green_a: assert property ( // [RL1]
        clk_en && cur.st == ST_ON && !charger_present && !batt_low
        |=> !led_red)
        else $error("Red lamp lit on healthy battery.");

    batt_red_a: assert property ( // [RL2]
        clk_en && cur.st == ST_ON && !charger_present && batt_low
        |=> !led_green)
        else $error("Green lamp lit on low battery.");

    full_green_a: assert property ( // [RL3]
        clk_en && cur.st == ST_ON && charger_present && batt_charged
        |=> !led_red)
        else $error("Red lamp lit with full batteries on supply.");

    charge_yellow_a: assert property ( // [RL4]
        clk_en && cur.st == ST_ON && charger_present && !batt_charged
        |=> led_green == led_red)
        else $error("Charging lamp is not yellow.");

    short_toggle_a: assert property ( // [RL5]
        clk_en && cur.st == ST_ON && release_short && !charger_present
        |=> cur.st == ST_OFF && !power_hold)
        else $error("Short press did not switch off.");

    long_hold_a: assert property ( // [RL6]
        clk_en && power_button ##1 (clk_en && forced)
        |=> cur.st == ST_FORCED && !power_hold)
        else $error("Long hold did not force shutdown.");

    charger_on_a: assert property ( // [RL7]
        clk_en && cur.st == ST_OFF && chg_rise && !forced
        |=> selfcheck_start ##0 power_hold)
        else $error("Charger attach did not start power-up.");

    charger_keep_a: assert property ( // [RL8]
        clk_en && cur.st == ST_ON && charger_present
        |=> cur.st inside {ST_ON, ST_FORCED})
        else $error("Unit left on state with charger attached.");

    idle_off_a: assert property ( // [RL9]
        clk_en && cur.st == ST_ON && idle_to && !charger_present && !forced
        |=> cur.st == ST_OFF)
        else $error("Idle limit did not switch off.");

    port_dark_a: assert property ( // [RL10]
        clk_en && !link_detect[0] |=> !port_led[0])
        else $error("Port lamp lit without a live link.");

    check_first_a: assert property ( // [RL13]
        $past(cur.st) == ST_OFF && cur.st != ST_OFF
        |-> cur.st inside {ST_CHECK, ST_FORCED})
        else $error("Power-on skipped the self check.");

    cover_power_on_c:  cover property (cur.st == ST_CHECK ##1 cur.st == ST_ON);
    cover_forced_c:    cover property (cur.st == ST_FORCED);
    cover_idle_off_c:  cover property (cur.st == ST_ON && idle_to);
    cover_yellow_c:    cover property (led_green && led_red);

endmodule

// >>> hdl/pwr_status_pkg.sv
// Constants, register map and state encoding for the power/status controller.
package pwr_status_pkg;

    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam longint CLK_HZ        = 250_000_000;
    localparam longint HOLD_TIME_S   = 4;
    localparam longint IDLE_TIME_S   = 350;
    localparam longint SLOW_HALF_MS  = 500;
    localparam longint FAST_HALF_MS  = 125;
    localparam longint MS_PER_S      = 1000;

    localparam logic [31:0] HOLD_CYCLES_DFLT = 32'(HOLD_TIME_S * CLK_HZ);
    localparam logic [39:0] IDLE_CYCLES_DFLT = 40'(IDLE_TIME_S * CLK_HZ);
    localparam logic [31:0] SLOW_CYCLES_DFLT =
        32'(SLOW_HALF_MS * CLK_HZ / MS_PER_S);
    localparam logic [31:0] FAST_CYCLES_DFLT =
        32'(FAST_HALF_MS * CLK_HZ / MS_PER_S);

    // ========================================================================
    // Ports and chaining
    // ========================================================================
    localparam int PORTS_PER_UNIT = 4;
    localparam int SEL_W          = 2;
    localparam int UNIT_W         = 2;

    // ========================================================================
    // Register map
    // ========================================================================
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_LINK   = 8'h08;
    localparam logic [7:0] REG_IDLE   = 8'h0c;

    localparam int CTRL_ACT_BIT    = 0;
    localparam int CTRL_FWUP_BIT   = 1;
    localparam int CTRL_SEL_LSB    = 4;

    localparam int STAT_STATE_LSB  = 0;
    localparam int STAT_CHG_BIT    = 2;
    localparam int STAT_LOW_BIT    = 3;
    localparam int STAT_FULL_BIT   = 4;
    localparam int STAT_FWUP_BIT   = 5;
    localparam int STAT_BASE_LSB   = 8;
    localparam int IDLE_MSB_SHIFT  = 8;

    // ========================================================================
    // Power states
    // ========================================================================
    typedef enum logic [1:0] {
        ST_OFF    = 2'h0,
        ST_CHECK  = 2'h1,
        ST_ON     = 2'h3,
        ST_FORCED = 2'h2
    } pwr_state_t;

endpackage

// >>> test/host_link_model.sv
// Behavioural host computer at the far end of the serial link.
`timescale 1ns/1ps

module host_link_model (
    // Clock
    input  wire logic pclk,
    // Serial lines
    input  wire logic host_tx,
    output logic      host_rx,
    output logic      serial_activity
);
    // ====================
    // Idle line
    // ====================
    // An idle serial line rests at mark level, so the model holds it high.
    initial
    begin
        host_rx         = 1'b1;
        serial_activity = 1'b0;
    end

    // ====================
    // Frame transfer
    // ====================
    // Image byte out.
    task automatic xfer(input logic [7:0] b, input int bitlen);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        @(posedge pclk);
        serial_activity <= 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            host_rx <= frame[i];
            repeat (bitlen) @(posedge pclk);
            serial_activity <= 1'b0;
        end
    endtask
endmodule

// >>> test/switch_box_power_status_ctrl_tb_top.sv
// Self-checking bench for the power and status controller.
`timescale 1ns/1ps

module switch_box_power_status_ctrl_tb_top;
    import pwr_status_pkg::*;

    localparam int HOLD = 20;
    localparam int IDLE = 200;

    logic        pclk, presetn, clk_en, psel, penable, pwrite, e, hr;
    logic [7:0]  paddr, seed;
    logic [31:0] pwdata, prdata, r;
    logic        pready, pslverr, power_button, charger_present;
    logic        batt_low, batt_charged, power_hold, selfcheck_start;
    logic        selfcheck_done, selfcheck_ok, led_green, led_red;
    logic        host_rx, host_tx, serial_activity, fw_update_mode;
    logic [3:0]  link_detect, probe_rx, probe_tx, port_led, acc, ep, pr;
    logic [1:0]  chain_upstream_port, chain_downstream_port;
    int          error_cnt, comparisons, m_state, fw, tg, tr, lg, lr, dm, n;

    switch_box_power_status_ctrl #(
        .HOLD_CYCLES(32'(HOLD)), .IDLE_CYCLES(40'(IDLE)),
        .SLOW_CYCLES(32'h8), .FAST_CYCLES(32'h2)
    ) dut (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .power_button(power_button), .charger_present(charger_present),
        .batt_low(batt_low), .batt_charged(batt_charged),
        .power_hold(power_hold), .selfcheck_start(selfcheck_start),
        .selfcheck_done(selfcheck_done), .selfcheck_ok(selfcheck_ok),
        .led_green(led_green), .led_red(led_red),
        .link_detect(link_detect), .probe_rx(probe_rx),
        .probe_tx(probe_tx), .port_led(port_led), .host_rx(host_rx),
        .host_tx(host_tx), .serial_activity(serial_activity),
        .fw_update_mode(fw_update_mode),
        .chain_upstream_port(chain_upstream_port),
        .chain_downstream_port(chain_downstream_port)
    );

    host_link_model hostm (
        .pclk(pclk), .host_tx(host_tx), .host_rx(host_rx),
        .serial_activity(serial_activity)
    );

    // ====================
    // Clock and watchdog
    // ====================
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        #60000;
        error_cnt++;
        final_report();
    end

    // ====================
    // Helpers and model
    // ====================
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // Expected status word built from the modelled state and the inputs.
    function automatic logic [31:0] exps();
        return 32'(m_state + 4 * charger_present + 8 * batt_low
            + 16 * batt_charged + 32 * fw + 1024 * chain_upstream_port);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask

    task automatic btn(input logic v, input int c);
        @(posedge pclk);
        power_button <= v;
        repeat (c) @(posedge pclk);
    endtask

    task automatic sc(input logic ok);
        @(posedge pclk);
        selfcheck_done <= 1'b1;
        selfcheck_ok   <= ok;
        @(posedge pclk);
        selfcheck_done <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    // Counts lamp toggles and lit cycles over eight fast or two slow periods.
    task automatic blink();
        logic g0, r0;
        {tg, tr, lg, lr, dm} = '0;
        acc = 4'h0;
        @(posedge pclk);
        #1;
        g0 = led_green;
        r0 = led_red;
        repeat (32)
        begin
            @(posedge pclk);
            #1;
            tg += int'(led_green !== g0);
            tr += int'(led_red !== r0);
            lg += int'(led_green);
            lr += int'(led_red);
            dm += int'(led_green !== led_red);
            acc |= port_led;
            g0 = led_green;
            r0 = led_red;
        end
    endtask

    task automatic final_report();
        if (error_cnt == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ====================
    // Main sequence
    // ====================
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, power_button} = '0;
        {charger_present, batt_low, batt_charged, selfcheck_done} = '0;
        {selfcheck_ok, link_detect, chain_upstream_port} = '0;
        clk_en   = 1'b1;
        probe_rx = 4'hf;
        seed     = 8'h3f;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        fork
            rdc(REG_STATUS, exps());
            begin
                repeat (2) @(posedge pclk);
                clk_en <= 1'b0;
                repeat (3) @(posedge pclk);
                clk_en <= 1'b1;
            end
        join
        chk(32'(power_hold), 32'h0);
        apb(1'b1, 8'h40, 32'hffff_ffff);
        chk(32'(e), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk(r | 32'(!e), 32'h0);
        btn(1'b1, 5);
        btn(1'b0, 3);
        m_state = ST_CHECK;
        rdc(REG_STATUS, exps());
        chk(32'({power_hold, selfcheck_start}), 32'h3);
        sc(1'b0);
        m_state = ST_OFF;
        rdc(REG_STATUS, exps());
        btn(1'b1, 5);
        btn(1'b0, 3);
        sc(1'b1);
        m_state = ST_ON;
        rdc(REG_STATUS, exps());
        fw = 1;
        apb(1'b1, REG_CTRL, 32'h2);
        repeat (2) @(posedge pclk);
        chk(32'(fw_update_mode), 32'h1);
        rdc(REG_STATUS, exps());
        seed = lfsr(seed);
        link_detect <= seed[7:4] ^ seed[3:0];
        for (int b = 0; b < 2; b++)
        begin
            batt_low <= 1'(b);
            repeat (3) @(posedge pclk);
            blink();
            chk(32'(b ? lg : lr), 32'h0);
            chk(32'((b ? tr : tg) inside {[3:5]}), 32'h1);
        end
        chk(32'(acc), 32'(link_detect));
        rdc(REG_LINK, 32'(link_detect));
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b1, REG_CTRL, 32'h2 | 32'(s << CTRL_SEL_LSB));
            rdc(REG_CTRL, 32'h2 | 32'(s << CTRL_SEL_LSB));
            fork
                hostm.xfer(seed, 1);
                repeat (10)
                begin
                    @(negedge pclk);
                    hr = host_rx;
                    pr = probe_rx;
                    @(posedge pclk);
                    probe_rx <= seed[3:0];
                    seed = lfsr(seed);
                    #1;
                    ep = 4'hf;
                    ep[s] = hr;
                    chk(32'(host_tx), 32'(pr[s]));
                    chk(32'(probe_tx), 32'(ep));
                end
            join
        end
        for (int u = 0; u < 4; u++)
        begin
            chain_upstream_port <= 2'(u);
            repeat (3) @(posedge pclk);
            chk(32'(chain_downstream_port), 32'((u + 1) % 4));
            rdc(REG_STATUS, exps());
        end
        batt_low        <= 1'b1;
        batt_charged    <= 1'b1;
        charger_present <= 1'b1;
        repeat (3) @(posedge pclk);
        blink();
        chk(32'(lr), 32'h0);
        chk(32'(tg > 11), 32'h1);
        batt_charged <= 1'b0;
        repeat (3) @(posedge pclk);
        blink();
        chk(32'(dm), 32'h0);
        chk(32'(tr > 11), 32'h1);
        btn(1'b1, 5);
        btn(1'b0, 3);
        rdc(REG_STATUS, exps());
        btn(1'b1, HOLD + 3);
        m_state = ST_FORCED;
        rdc(REG_STATUS, exps());
        chk(32'(power_hold), 32'h0);
        btn(1'b0, 3);
        m_state = ST_OFF;
        rdc(REG_STATUS, exps());
        charger_present <= 1'b0;
        repeat (3) @(posedge pclk);
        charger_present <= 1'b1;
        repeat (3) @(posedge pclk);
        m_state = ST_CHECK;
        rdc(REG_STATUS, exps());
        sc(1'b1);
        charger_present <= 1'b0;
        batt_low        <= 1'b0;
        btn(1'b1, 5);
        btn(1'b0, 3);
        m_state = ST_OFF;
        rdc(REG_STATUS, exps());
        btn(1'b1, 5);
        btn(1'b0, 3);
        sc(1'b1);
        m_state = ST_ON;
        fw = 0;
        apb(1'b1, REG_CTRL, 32'h0);
        repeat (120) @(posedge pclk);
        hostm.xfer(8'h5a, 3);
        repeat (150) @(posedge pclk);
        chk(32'(power_hold), 32'h1);
        apb(1'b1, REG_CTRL, 32'h1);
        repeat (150) @(posedge pclk);
        chk(32'(power_hold), 32'h1);
        n = 0;
        while (power_hold !== 1'b0 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n < 100), 32'h1);
        m_state = ST_OFF;
        rdc(REG_STATUS, exps());
        rdc(REG_IDLE, 32'h0);
        final_report();
    end
endmodule
